// File: verilog/pixel_pipeline_config_registers.sv
// Configuration bank of the programmable pixel pipeline: words 1..15, microcode store, palette memory.
// Assumes a classic Wishbone master on clk_i and a pixel sequencer on the same clock.
//
// Decided for this implementation: register access over Wishbone.
`timescale 1ns/1ps

// How it works
// R1: First texture base is bits 13..0 of its base word, in 2048-byte steps.
// R2: Second texture base is bits 13..0 of its base word, in 2048-byte steps.
// R3: Microcode texture-select bit chooses which texture descriptor applies to a fetch.
// R4: Depth buffer base is bits 29..16 of buffer bases, times 2048 bytes.
// R5: Colour buffer base is bits 13..0 of buffer bases, times 2048 bytes.
// R6: Stencil field bits 10..9: keep, set, clear or invert.
// R7: Microcode execution starts at the five-bit entry in bits 4..0.
// R8: Second texture palette index is masked by bits 31..24.
// R9: Masked second texture index is combined with base bits 23..16.
// R10: First texture palette index is masked by bits 15..8.
// R11: Masked first texture index is combined with base bits 7..0.
// R12: Thirty-two word microcode store sits at word indexes 128 to 159.
// R13: Palette memory sits at word indexes 256 to 511.
// R14: Words 0 and 16 ignore writes and read as zero.
module pixel_pipeline_config_registers #(
	parameter int unsigned UCODE_DEPTH = 32,
	parameter int unsigned PAL_DEPTH = 256,
	parameter int unsigned TEX_SEL_BIT = 31
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_b_i,
	// Wishbone slave
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic we_i,
	input wire logic [10:0] adr_i,
	input wire logic [3:0] sel_i,
	input wire logic [31:0] dat_i,
	output logic [31:0] dat_o,
	output logic ack_o,
	// Microcode sequencer
	input wire logic run_start_i,
	input wire logic run_step_i,
	output logic [4:0] pc_o,
	output logic [31:0] instr_o,
	// Texture descriptor of the current instruction
	output pixcfg_pkg::tex_desc_t tex_desc_o,
	// Palette lookup
	input wire logic pal_req_i,
	input wire logic [7:0] pal_texel_i,
	output logic [31:0] pal_data_o,
	output logic pal_valid_o,
	// Frame configuration
	output pixcfg_pkg::argb_t coef_0_o,
	output pixcfg_pkg::argb_t coef_1_o,
	output pixcfg_pkg::argb_t coef_2_o,
	output pixcfg_pkg::argb_t coef_3_o,
	output pixcfg_pkg::buf_bases_t bases_o,
	output pixcfg_pkg::sten_op_t sten_op_o,
	output logic [31:0] dither_o,
	output logic [31:0] modulation_o,
	output logic [31:0] pixel_mode_o,
	output logic [31:0] frame_mode_o
);

	// ------------------------------------------------------------
	// Address decode
	// ------------------------------------------------------------
	localparam int unsigned PC_W = $clog2(UCODE_DEPTH);
	localparam int unsigned PAL_AW = $clog2(PAL_DEPTH);

	logic [pixcfg_pkg::IDX_W-1:0] idx;
	logic req;
	logic hit_cfg;
	logic hit_ucode;
	logic hit_pal;
	logic wr_go;

	assign idx = adr_i[pixcfg_pkg::ADR_MSB:pixcfg_pkg::BYTE_LSB];
	assign req = cyc_i && stb_i && !ack_o;
	// Index 0 and 16 and everything else unmapped fall out of all three hits.
	assign hit_cfg = (idx >= pixcfg_pkg::IDX_COEF_0) && (idx <= pixcfg_pkg::IDX_PALETTE_IDX); // R14
	assign hit_ucode = (idx >= pixcfg_pkg::IDX_UCODE_FIRST) && (idx <= pixcfg_pkg::IDX_UCODE_LAST); // R12
	assign hit_pal = (idx >= pixcfg_pkg::IDX_PAL_FIRST) && (idx <= pixcfg_pkg::IDX_PAL_LAST); // R13
	// A write lands on the edge at which the master sees ack high, while it still holds
	// address, lanes and data, so a word never changes before its bus cycle ends.
	assign wr_go = cyc_i && stb_i && we_i && ack_o;

	// ------------------------------------------------------------
	// Configuration words 1..15
	// ------------------------------------------------------------
	logic [31:0] cfg [1:pixcfg_pkg::NUM_CFG];

	for (genvar g = 1; g <= pixcfg_pkg::NUM_CFG; g++) begin : g_cfg
		cfg_word u_word (
			.clk_i(clk_i),
			.rst_b_i(rst_b_i),
			.wr_i(wr_go && hit_cfg && (idx == pixcfg_pkg::IDX_W'(g))),
			.sel_i(sel_i),
			.data_i(dat_i),
			.q_o(cfg[g])
		);
	end

	// ------------------------------------------------------------
	// Microcode store and palette memory
	// ------------------------------------------------------------
	// Contents are not reset: software loads both before enabling the pipeline.
	// A host write and a pipeline read of one word in the same cycle give the pipeline the old word.
	// Patching microcode while a frame runs is therefore unsafe.
	logic [31:0] ucode [0:UCODE_DEPTH-1];
	logic [31:0] pal_mem [0:PAL_DEPTH-1];
	logic [PC_W-1:0] ucode_wa;
	logic [PAL_AW-1:0] pal_wa;

	assign ucode_wa = idx[PC_W-1:0];
	assign pal_wa = idx[PAL_AW-1:0];

	always_ff @(posedge clk_i) begin
		if (wr_go && hit_ucode) begin
			for (int b = 0; b < 4; b++) begin
				if (sel_i[b]) begin
					ucode[ucode_wa][b*8 +: 8] <= dat_i[b*8 +: 8]; // R12
				end
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (wr_go && hit_pal) begin
			for (int b = 0; b < 4; b++) begin
				if (sel_i[b]) begin
					pal_mem[pal_wa][b*8 +: 8] <= dat_i[b*8 +: 8]; // R13
				end
			end
		end
	end

	// ------------------------------------------------------------
	// Bus answer
	// ------------------------------------------------------------
	logic [31:0] next_dat;

	always_comb begin
		next_dat = pixcfg_pkg::READ_ZERO;
		if (hit_cfg) begin
			next_dat = cfg[idx[pixcfg_pkg::CFG_SEL_W-1:0]];
		end else if (hit_ucode) begin
			next_dat = ucode[ucode_wa];
		end else if (hit_pal) begin
			next_dat = pal_mem[pal_wa];
		end
	end

	// Every access, mapped or not, is answered one cycle after the request.
	// There is no error answer, so a stray pointer never hangs the host bus.
	always_ff @(posedge clk_i) begin
		if (!rst_b_i) begin
			ack_o <= 1'b0;
		end else begin
			ack_o <= req;
		end
	end

	// Read data is captured when the request is taken and stands until the next read.
	always_ff @(posedge clk_i) begin
		if (!rst_b_i) begin
			dat_o <= pixcfg_pkg::READ_ZERO;
		end else if (req && !we_i) begin
			dat_o <= next_dat; // R14
		end
	end

	// ------------------------------------------------------------
	// Microcode sequencer
	// ------------------------------------------------------------
	logic [PC_W-1:0] pc;
	logic [PC_W-1:0] entry;

	assign entry = cfg[pixcfg_pkg::IDX_UCODE_ENTRY][pixcfg_pkg::ENTRY_LSB +: PC_W];

	// A start wins over a step in the same cycle, so a new frame never skips its entry word.
	// The counter wraps at the store depth, so running off the last word restarts at word zero.
	always_ff @(posedge clk_i) begin
		if (!rst_b_i) begin
			pc <= '0;
		end else if (run_start_i) begin
			pc <= entry; // R7
		end else if (run_step_i) begin
			pc <= pc + PC_W'(1);
		end
	end

	always_ff @(posedge clk_i) begin
		if (!rst_b_i) begin
			pc_o <= '0;
			instr_o <= pixcfg_pkg::READ_ZERO;
		end else begin
			pc_o <= 5'(pc);
			instr_o <= ucode[pc];
		end
	end

	// ------------------------------------------------------------
	// Texture descriptor selection
	// ------------------------------------------------------------
	logic tex_b;
	logic [31:0] sel_base_word;
	logic [31:0] sel_params_word;
	logic [pixcfg_pkg::TEX_BASE_W-1:0] sel_base;

	// The select bit comes from the instruction, never from the coordinate source.
	// The descriptor lags the instruction by one cycle; the fetch logic must pair them.
	assign tex_b = instr_o[TEX_SEL_BIT]; // R3
	assign sel_base_word = tex_b ? cfg[pixcfg_pkg::IDX_TEX_B_BASE] : cfg[pixcfg_pkg::IDX_TEX_A_BASE];
	assign sel_params_word = tex_b ? cfg[pixcfg_pkg::IDX_TEX_B_PARAMS] : cfg[pixcfg_pkg::IDX_TEX_A_PARAMS];
	assign sel_base = sel_base_word[pixcfg_pkg::TEX_BASE_LSB +: pixcfg_pkg::TEX_BASE_W];

	always_ff @(posedge clk_i) begin
		if (!rst_b_i) begin
			tex_desc_o <= '0;
		end else begin
			tex_desc_o.base_byte <= 32'(sel_base) << pixcfg_pkg::UNIT_SHIFT; // R1 R2
			tex_desc_o.mip_height <= sel_base_word[pixcfg_pkg::TEX_MHIG_LSB +: pixcfg_pkg::TEX_MHIG_W];
			tex_desc_o.params <= sel_params_word;
		end
	end

	// ------------------------------------------------------------
	// Palette lookup
	// ------------------------------------------------------------
	logic [31:0] pal_cfg;
	logic [7:0] pal_mask;
	logic [7:0] pal_base;
	logic [7:0] pal_index;

	assign pal_cfg = cfg[pixcfg_pkg::IDX_PALETTE_IDX];
	assign pal_mask = tex_b ? pal_cfg[pixcfg_pkg::PAL_B_MASK_LSB +: pixcfg_pkg::PAL_W] // R8
		: pal_cfg[pixcfg_pkg::PAL_A_MASK_LSB +: pixcfg_pkg::PAL_W]; // R10
	assign pal_base = tex_b ? pal_cfg[pixcfg_pkg::PAL_B_BASE_LSB +: pixcfg_pkg::PAL_W] // R9
		: pal_cfg[pixcfg_pkg::PAL_A_BASE_LSB +: pixcfg_pkg::PAL_W]; // R11
	// Masked index is ORed onto the base so sub-palettes tile the 256 entries.
	// Texture select is sampled with the request, so a lookup as the instruction changes uses the old one.
	assign pal_index = (pal_texel_i & pal_mask) | pal_base; // R8 R9 R10 R11

	always_ff @(posedge clk_i) begin
		if (!rst_b_i) begin
			pal_valid_o <= 1'b0;
		end else begin
			pal_valid_o <= pal_req_i;
		end
	end

	always_ff @(posedge clk_i) begin
		if (!rst_b_i) begin
			pal_data_o <= pixcfg_pkg::READ_ZERO;
		end else if (pal_req_i) begin
			pal_data_o <= pal_mem[PAL_AW'(pal_index)];
		end
	end

	// ------------------------------------------------------------
	// Frame configuration outputs
	// ------------------------------------------------------------
	logic [31:0] bases_word;
	logic [pixcfg_pkg::TEX_BASE_W-1:0] zbase;
	logic [pixcfg_pkg::TEX_BASE_W-1:0] cbase;

	assign bases_word = cfg[pixcfg_pkg::IDX_BUFFER_BASES];
	assign zbase = bases_word[pixcfg_pkg::ZBASE_LSB +: pixcfg_pkg::TEX_BASE_W];
	assign cbase = bases_word[pixcfg_pkg::CBASE_LSB +: pixcfg_pkg::TEX_BASE_W];

	always_ff @(posedge clk_i) begin
		if (!rst_b_i) begin
			bases_o <= '0;
		end else begin
			bases_o.zbase_byte <= 32'(zbase) << pixcfg_pkg::UNIT_SHIFT; // R4
			bases_o.cbase_byte <= 32'(cbase) << pixcfg_pkg::UNIT_SHIFT; // R5
		end
	end

	always_ff @(posedge clk_i) begin
		if (!rst_b_i) begin
			sten_op_o <= pixcfg_pkg::STEN_KEEP;
		end else begin
			sten_op_o <= pixcfg_pkg::sten_op_t'(
				cfg[pixcfg_pkg::IDX_PIXEL_OP][pixcfg_pkg::STEN_OP_LSB +: pixcfg_pkg::STEN_OP_W]); // R6
		end
	end

	// Each copy has its own flip-flop stage, so every output settles one cycle after its word is written.
	// Blend coefficients are passed whole; the channel split lives in the carrier type.
	always_ff @(posedge clk_i) begin
		if (!rst_b_i) begin
			coef_0_o <= '0;
		end else begin
			coef_0_o <= cfg[pixcfg_pkg::IDX_COEF_0];
		end
	end

	always_ff @(posedge clk_i) begin
		if (!rst_b_i) begin
			coef_1_o <= '0;
		end else begin
			coef_1_o <= cfg[pixcfg_pkg::IDX_COEF_0 + pixcfg_pkg::IDX_W'(1)];
		end
	end

	always_ff @(posedge clk_i) begin
		if (!rst_b_i) begin
			coef_2_o <= '0;
		end else begin
			coef_2_o <= cfg[pixcfg_pkg::IDX_COEF_0 + pixcfg_pkg::IDX_W'(2)];
		end
	end

	always_ff @(posedge clk_i) begin
		if (!rst_b_i) begin
			coef_3_o <= '0;
		end else begin
			coef_3_o <= cfg[pixcfg_pkg::IDX_COEF_3];
		end
	end

	always_ff @(posedge clk_i) begin
		if (!rst_b_i) begin
			dither_o <= pixcfg_pkg::CFG_RESET;
		end else begin
			dither_o <= cfg[pixcfg_pkg::IDX_DITHER];
		end
	end

	always_ff @(posedge clk_i) begin
		if (!rst_b_i) begin
			modulation_o <= pixcfg_pkg::CFG_RESET;
		end else begin
			modulation_o <= cfg[pixcfg_pkg::IDX_SCREEN_MOD];
		end
	end

	always_ff @(posedge clk_i) begin
		if (!rst_b_i) begin
			pixel_mode_o <= pixcfg_pkg::CFG_RESET;
		end else begin
			pixel_mode_o <= cfg[pixcfg_pkg::IDX_PIXEL_OP];
		end
	end

	always_ff @(posedge clk_i) begin
		if (!rst_b_i) begin
			frame_mode_o <= pixcfg_pkg::CFG_RESET;
		end else begin
			frame_mode_o <= cfg[pixcfg_pkg::IDX_FRAME_MODE];
		end
	end

endmodule

// File: pkg/pixcfg_pkg.sv
// Shared constants and carrier types of the pixel pipeline configuration bank.
// Assumes a 32-bit word bus; register indexes are word indexes, byte address = 4 x index.
package pixcfg_pkg;

	// ------------------------------------------------------------
	// Address map (word indexes)
	// ------------------------------------------------------------
	localparam int unsigned IDX_W = 9;
	localparam int unsigned BYTE_LSB = 2;
	localparam int unsigned ADR_MSB = 10;
	localparam int unsigned CFG_SEL_W = 4;
	localparam logic [IDX_W-1:0] IDX_UNUSED = 9'h000;
	localparam logic [IDX_W-1:0] IDX_COEF_0 = 9'h001;
	localparam logic [IDX_W-1:0] IDX_COEF_3 = 9'h004;
	localparam logic [IDX_W-1:0] IDX_TEX_A_BASE = 9'h005;
	localparam logic [IDX_W-1:0] IDX_TEX_A_PARAMS = 9'h006;
	localparam logic [IDX_W-1:0] IDX_TEX_B_BASE = 9'h007;
	localparam logic [IDX_W-1:0] IDX_TEX_B_PARAMS = 9'h008;
	localparam logic [IDX_W-1:0] IDX_BUFFER_BASES = 9'h009;
	localparam logic [IDX_W-1:0] IDX_DITHER = 9'h00a;
	localparam logic [IDX_W-1:0] IDX_SCREEN_MOD = 9'h00b;
	localparam logic [IDX_W-1:0] IDX_PIXEL_OP = 9'h00c;
	localparam logic [IDX_W-1:0] IDX_FRAME_MODE = 9'h00d;
	localparam logic [IDX_W-1:0] IDX_UCODE_ENTRY = 9'h00e;
	localparam logic [IDX_W-1:0] IDX_PALETTE_IDX = 9'h00f;
	localparam logic [IDX_W-1:0] IDX_RESERVED = 9'h010;
	localparam logic [IDX_W-1:0] IDX_UCODE_FIRST = 9'h080;
	localparam logic [IDX_W-1:0] IDX_UCODE_LAST = 9'h09f;
	localparam logic [IDX_W-1:0] IDX_PAL_FIRST = 9'h100;
	localparam logic [IDX_W-1:0] IDX_PAL_LAST = 9'h1ff;
	localparam int unsigned NUM_CFG = 15;

	// ------------------------------------------------------------
	// Field positions
	// ------------------------------------------------------------
	localparam int unsigned TEX_BASE_LSB = 0;
	localparam int unsigned TEX_BASE_W = 14;
	localparam int unsigned TEX_MHIG_LSB = 16;
	localparam int unsigned TEX_MHIG_W = 6;
	localparam int unsigned ZBASE_LSB = 16;
	localparam int unsigned CBASE_LSB = 0;
	localparam int unsigned STEN_OP_LSB = 9;
	localparam int unsigned STEN_OP_W = 2;
	localparam int unsigned ENTRY_LSB = 0;
	localparam int unsigned ENTRY_W = 5;
	localparam int unsigned PAL_B_MASK_LSB = 24;
	localparam int unsigned PAL_B_BASE_LSB = 16;
	localparam int unsigned PAL_A_MASK_LSB = 8;
	localparam int unsigned PAL_A_BASE_LSB = 0;
	localparam int unsigned PAL_W = 8;
	localparam int unsigned UNIT_SHIFT = 11;
	localparam int unsigned UNIT_BYTES = 2048;
	localparam logic [31:0] CFG_RESET = 32'h0000_0000;
	localparam logic [31:0] READ_ZERO = 32'h0000_0000;

	// ------------------------------------------------------------
	// Carrier types
	// ------------------------------------------------------------
	typedef struct packed {
		logic [7:0] alpha;
		logic [7:0] red;
		logic [7:0] green;
		logic [7:0] blue;
	} argb_t;

	typedef enum logic [1:0] {
		STEN_KEEP = 2'h0,
		STEN_SET = 2'h1,
		STEN_CLEAR = 2'h2,
		STEN_INVERT = 2'h3
	} sten_op_t;

	typedef struct packed {
		logic [31:0] base_byte;
		logic [TEX_MHIG_W-1:0] mip_height;
		logic [31:0] params;
	} tex_desc_t;

	typedef struct packed {
		logic [31:0] zbase_byte;
		logic [31:0] cbase_byte;
	} buf_bases_t;

endpackage

// File: verilog/cfg_word.sv
// One 32-bit configuration word with per-byte write enables.
// Assumes the caller gates the write strobe with its own address decode.
`timescale 1ns/1ps

module cfg_word (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_b_i,
	// Write side
	input wire logic wr_i,
	input wire logic [3:0] sel_i,
	input wire logic [31:0] data_i,
	// Stored word
	output logic [31:0] q_o
);

	always_ff @(posedge clk_i) begin
		if (!rst_b_i) begin
			q_o <= pixcfg_pkg::CFG_RESET;
		end else if (wr_i) begin
			for (int b = 0; b < 4; b++) begin
				if (sel_i[b]) begin
					q_o[b*8 +: 8] <= data_i[b*8 +: 8];
				end
			end
		end
	end

endmodule

// File: bench/pixcfg_sva.sv
// Concurrent checks of the configuration bank, watching only its top ports.
// Assumes field checks only see whole-word writes (sel_i 4'hf).
`timescale 1ns/1ps

module pixcfg_sva (
	// Bus side
	input wire logic clk_i,
	input wire logic rst_b_i,
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic we_i,
	input wire logic [10:0] adr_i,
	input wire logic [3:0] sel_i,
	input wire logic [31:0] dat_i,
	input wire logic [31:0] dat_o,
	input wire logic ack_o,
	// Pipeline side
	input wire logic run_start_i,
	input wire logic [4:0] pc_o,
	input wire logic [31:0] instr_o,
	input wire pixcfg_pkg::tex_desc_t tex_desc_o,
	input wire logic pal_req_i,
	input wire logic pal_valid_o,
	input wire pixcfg_pkg::buf_bases_t bases_o,
	input wire pixcfg_pkg::sten_op_t sten_op_o
);
	logic take;
	logic wf;
	logic [8:0] idx;
	logic [31:0] ent;
	logic [31:0] tex_a;
	logic [31:0] tex_b;
	assign idx = adr_i[10:2];
	assign take = cyc_i && stb_i && !ack_o;
	// Writes land on the edge at which ack is high, so the shadows follow that edge.
	assign wf = cyc_i && stb_i && we_i && ack_o && sel_i == 4'hf;

	// -----------------------------
	// Shadow words
	// -----------------------------
	always_ff @(posedge clk_i) begin
		if (!rst_b_i) begin
			ent <= 32'h0000_0000;
			tex_a <= 32'h0000_0000;
			tex_b <= 32'h0000_0000;
		end else if (wf) begin
			if (idx == pixcfg_pkg::IDX_UCODE_ENTRY) ent <= dat_i;
			if (idx == pixcfg_pkg::IDX_TEX_A_BASE) tex_a <= dat_i;
			if (idx == pixcfg_pkg::IDX_TEX_B_BASE) tex_b <= dat_i;
		end
	end

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rst_b_i);

	ack_follow_a: assert property (take |=> ack_o) else $error("ack missing after request");
	ack_pulse_a: assert property (ack_o |=> !ack_o) else $error("ack held too long");
	zero_read_a: assert property (take && !we_i && (idx == 9'h000 || idx == 9'h010) |=> dat_o == 32'h0000_0000)
		else $error("unused word read not zero");
	depth_base_a: assert property (wf && idx == 9'h009 |=> ##1 bases_o.zbase_byte == {7'h00, $past(dat_i[29:16], 2), 11'h000})
		else $error("depth base wrong");
	colour_base_a: assert property (wf && idx == 9'h009 |=> ##1 bases_o.cbase_byte == {7'h00, $past(dat_i[13:0], 2), 11'h000})
		else $error("colour base wrong");
	stencil_field_a: assert property (wf && idx == 9'h00c |=> ##1 sten_op_o == $past(dat_i[10:9], 2))
		else $error("stencil op wrong");
	entry_load_a: assert property (run_start_i |=> ##1 pc_o == ent[4:0])
		else $error("pc not loaded from entry");
	tex_first_a: assert property (!instr_o[31] && !wf |=> tex_desc_o.base_byte == {7'h00, tex_a[13:0], 11'h000})
		else $error("first texture base wrong");
	tex_second_a: assert property (instr_o[31] && !wf |=> tex_desc_o.base_byte == {7'h00, tex_b[13:0], 11'h000})
		else $error("second texture base wrong");
	pal_answer_a: assert property (pal_req_i |=> pal_valid_o) else $error("palette answer missing");
endmodule

// File: bench/test_pixel_pipeline_config_registers.sv
// Self-checking bench of the configuration bank, driven over classic Wishbone.
// Assumes the bench alone drives the sequencer and palette request inputs.
`timescale 1ns/1ps

module test_pixel_pipeline_config_registers;
	logic clk_i = 1'b0;
	logic rst_b_i = 1'b0;
	logic cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0;
	logic [10:0] adr_i = 11'h000;
	logic [3:0] sel_i = 4'h0;
	logic [31:0] dat_i = 32'h0000_0000;
	logic run_start_i = 1'b0, run_step_i = 1'b0, pal_req_i = 1'b0;
	logic [7:0] pal_texel_i = 8'h00;
	logic [31:0] dat_o, instr_o, pal_data_o, rd, w;
	logic ack_o, pal_valid_o;
	logic [4:0] pc_o;
	pixcfg_pkg::tex_desc_t tex_desc_o;
	pixcfg_pkg::buf_bases_t bases_o;
	pixcfg_pkg::sten_op_t sten_op_o;
	pixcfg_pkg::argb_t coef_0_o, coef_1_o, coef_2_o, coef_3_o;
	logic [31:0] dither_o, modulation_o, pixel_mode_o, frame_mode_o;
	int miscompares = 0, cmp_count = 0;
	always #12.5 clk_i = ~clk_i;

	pixel_pipeline_config_registers DUT (.clk_i(clk_i), .rst_b_i(rst_b_i), .cyc_i(cyc_i), .stb_i(stb_i),
		.we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
		.run_start_i(run_start_i), .run_step_i(run_step_i), .pc_o(pc_o), .instr_o(instr_o),
		.tex_desc_o(tex_desc_o), .pal_req_i(pal_req_i), .pal_texel_i(pal_texel_i), .pal_data_o(pal_data_o),
		.pal_valid_o(pal_valid_o), .coef_0_o(coef_0_o), .coef_1_o(coef_1_o), .coef_2_o(coef_2_o),
		.coef_3_o(coef_3_o), .bases_o(bases_o), .sten_op_o(sten_op_o), .dither_o(dither_o),
		.modulation_o(modulation_o), .pixel_mode_o(pixel_mode_o), .frame_mode_o(frame_mode_o));

	// -----------------------------
	// Tasks
	// -----------------------------
	function automatic logic [31:0] pat(input int i);
		return 32'h9E37_79B9 ^ (i * 32'h0104_0B11);
	endfunction
	task automatic print_verdict();
		$display("compares %0d mismatches %0d", cmp_count, miscompares);
		if (miscompares == 0 && cmp_count > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			miscompares++;
			$display("mismatch %s expected %h seen %h", name, exp, seen);
		end
	endtask
	// The request is held until ack is seen high at a rising edge, then released.
	task automatic wb(input logic we, input int idx, input logic [3:0] sel, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk_i);
		cyc_i <= 1'b1;
		stb_i <= 1'b1;
		we_i <= we;
		sel_i <= sel;
		dat_i <= d;
		adr_i <= {idx[8:0], 2'b00};
		// Ack and read data are read at the rising edge, before that edge's own update lands.
		do begin
			@(posedge clk_i);
			n++;
		end while (ack_o !== 1'b1 && n < 20);
		if (ack_o !== 1'b1) begin
			miscompares++;
			print_verdict();
		end else begin
			rd = dat_o;
			cyc_i <= 1'b0;
			stb_i <= 1'b0;
			we_i <= 1'b0;
		end
	endtask
	task automatic rc(input int idx, input logic [31:0] exp);
		wb(1'b0, idx, 4'hf, 32'h0000_0000);
		chk("read word", rd, exp);
	endtask
	task automatic seq(input logic start, input logic [4:0] pc, input logic [31:0] base, input logic [31:0] prm);
		@(posedge clk_i);
		run_start_i <= start;
		run_step_i <= !start;
		@(posedge clk_i);
		run_start_i <= 1'b0;
		run_step_i <= 1'b0;
		repeat (2) @(posedge clk_i);
		@(negedge clk_i);
		chk("pc", {27'h0, pc_o}, {27'h0, pc});
		chk("instr", instr_o, {pc[0], 26'h0, pc});
		chk("tex base", tex_desc_o.base_byte, {7'h00, base[13:0], 11'h000});
		chk("mip height", {26'h0, tex_desc_o.mip_height}, {26'h0, base[21:16]});
		chk("tex params", tex_desc_o.params, prm);
	endtask
	task automatic look(input logic [7:0] t, input logic [31:0] exp);
		@(posedge clk_i);
		pal_req_i <= 1'b1;
		pal_texel_i <= t;
		@(posedge clk_i);
		pal_req_i <= 1'b0;
		@(negedge clk_i);
		chk("pal valid", {31'h0, pal_valid_o}, 32'h0000_0001);
		chk("pal data", pal_data_o, exp);
	endtask

	initial begin
		repeat (2) @(posedge clk_i);
		rst_b_i <= 1'b1;
		for (int i = 1; i < 16; i++) rc(i, 32'h0000_0000);
		for (int i = 0; i < 17; i++) wb(1'b1, i, 4'hf, pat(i));
		for (int i = 0; i < 17; i++) rc(i, (i == 0 || i == 16) ? 32'h0000_0000 : pat(i));
		chk("coef 0", coef_0_o, pat(1));
		w = pat(9);
		chk("depth base", bases_o.zbase_byte, {7'h00, w[29:16], 11'h000});
		chk("colour base", bases_o.cbase_byte, {7'h00, w[13:0], 11'h000});
		chk("coef 1", coef_1_o, pat(2));
		chk("coef 2", coef_2_o, pat(3));
		chk("coef 3", coef_3_o, pat(4));
		chk("dither", dither_o, pat(10));
		chk("modulation", modulation_o, pat(11));
		chk("pixel mode", pixel_mode_o, pat(12));
		chk("frame mode", frame_mode_o, pat(13));
		for (int k = 0; k < 4; k++) begin
			wb(1'b1, 12, 4'hf, k << 9);
			repeat (2) @(negedge clk_i);
			chk("stencil op", {30'h0, sten_op_o}, k);
		end
		wb(1'b1, 10, 4'h2, 32'hFFFF_FFFF);
		rc(10, pat(10) | 32'h0000_FF00);
		chk("dither lane", dither_o, pat(10) | 32'h0000_FF00);
		for (int i = 0; i < 32; i++) wb(1'b1, 128 + i, 4'hf, {i[0], 26'h0, i[4:0]});
		rc(159, 32'h8000_001F);
		for (int k = 0; k < 256; k++) wb(1'b1, 256 + k, 4'hf, 32'h5A00_0000 | k);
		rc(511, 32'h5A00_00FF);
		wb(1'b1, 15, 4'hf, 32'h0F30_F005);
		wb(1'b1, 14, 4'hf, 32'hFFFF_FFFE);
		seq(1'b1, 5'd30, pat(5), pat(6));
		look(8'hAB, 32'h5A00_00A5);
		seq(1'b0, 5'd31, pat(7), pat(8));
		look(8'hAB, 32'h5A00_003B);
		seq(1'b0, 5'd0, pat(5), pat(6));
		print_verdict();
	end
endmodule

bind pixel_pipeline_config_registers pixcfg_sva chk_u (.clk_i(clk_i), .rst_b_i(rst_b_i), .cyc_i(cyc_i),
	.stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
	.run_start_i(run_start_i), .pc_o(pc_o), .instr_o(instr_o), .tex_desc_o(tex_desc_o),
	.pal_req_i(pal_req_i), .pal_valid_o(pal_valid_o), .bases_o(bases_o), .sten_op_o(sten_op_o));
